// ---- logic/u_loop_regs.svh ----
// Command codes, message codes and highway slot positions for the loop-back control.
// Assumes the highway frame carries B1, B2, monitor and D slots in that bit order.
`ifndef U_LOOP_REGS_SVH
`define U_LOOP_REGS_SVH

// ----------------------------------------------------------------
// Command/indicate codes (4 bit)
// ----------------------------------------------------------------
`define CI_RESET_CODE       4'h1
`define CI_LOOP_ACT_REQ     4'hA
`define CI_DEACT_CONFIRM    4'hF
`define CI_ACT_REQUEST      4'h8
`define CI_ACT_IND_LOOP     4'hE

// ----------------------------------------------------------------
// Monitor message codes (8 bit)
// ----------------------------------------------------------------
`define MSG_REMOTE_COMPLETE 8'h50
`define MSG_REMOTE_FIRST    8'h51
`define MSG_REMOTE_SECOND   8'h52
`define MSG_RETURN_NORMAL   8'hFF
`define MSG_LOCAL_COMPLETE  8'hF1
`define MSG_LOCAL_FIRST     8'hF4
`define MSG_LOCAL_SECOND    8'hF2
`define MSG_LOCAL_NORMAL    8'hFF

// ----------------------------------------------------------------
// Highway frame bit positions
// ----------------------------------------------------------------
`define SLOT_FIRST_LO       5'h00
`define SLOT_FIRST_HI       5'h07
`define SLOT_SECOND_LO      5'h08
`define SLOT_SECOND_HI      5'h0F
`define SLOT_D_LO           5'h18
`define SLOT_D_HI           5'h19
`define FRAME_POS_ZERO      5'h00
`define FRAME_POS_STEP      5'h01

`endif

// ---- logic/u_loop_pkg.sv ----
// Types shared by the loop-back control files.
// Assumes nothing of its surroundings.
package u_loop_pkg;

	// ----------------------------------------------------------------
	// Analog loop sequencing states, one-hot
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		ALOOP_OPEN     = 3'b001,
		ALOOP_WAIT_ACT = 3'b010,
		ALOOP_CLOSED   = 3'b100
	} analog_state_type;

endpackage : u_loop_pkg

// ---- logic/loop_fifo.sv ----
// Small synchronous FIFO carrying looped highway bits.
// Assumes a single clock and an asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none

module loop_fifo #(
	parameter int WIDTH = 1,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input  wire logic             clk_sys_i,
	input  wire logic             reset_n_i,
	input  wire logic             flush_i,
	// Fill side
	input  wire logic [WIDTH-1:0] in_data_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	// Drain side
	output logic [WIDTH-1:0]      out_data_o,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	// Refuse shapes the pointer logic cannot serve
	generate
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1)
		begin : g_bad
			$error("loop_fifo needs a power-of-two depth of two or more");
		end
	endgenerate

	logic [WIDTH-1:0] mem_reg [DEPTH];  // Storage
	logic [AW-1:0]    wr_ptr_reg;       // Write index
	logic [AW-1:0]    rd_ptr_reg;       // Read index
	logic [AW:0]      count_reg;        // Occupancy
	logic             push;             // Accepted write
	logic             pop;              // Accepted read

	assign in_ready_o  = (count_reg != DEPTH[AW:0]);
	assign out_valid_o = (count_reg != '0);
	assign out_data_o  = mem_reg[rd_ptr_reg];
	assign push        = in_valid_i & in_ready_o;
	assign pop         = out_valid_o & out_ready_i;

	// Storage writes need no reset; only pointers and occupancy carry control state
	always_ff @(posedge clk_sys_i)
	begin
		if (push)
			mem_reg[wr_ptr_reg] <= in_data_i;
	end

	// Pointers and occupancy
	always_ff @(posedge clk_sys_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end
		else if (flush_i)
		begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end
		else
		begin
			if (push)
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			if (pop)
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			if (push && !pop)
				count_reg <= count_reg + 1'b1;
			else if (pop && !push)
				count_reg <= count_reg - 1'b1;
		end
	end

endmodule : loop_fifo
`default_nettype wire

// ---- logic/u_line_loopback_control.sv ----
// Test loop-back control of a two-wire line transceiver: analog and digital loops.
// Assumes command codes and monitor messages arrive already deframed on clk_sys_i,
// and the highway clocks and data pins arrive asynchronously.
`timescale 1ns/1ps
`default_nettype none
`include "u_loop_regs.svh"

module u_line_loopback_control #(
	parameter int FIFO_DEPTH = 8
) (
	// Clock and reset
	input  wire logic       clk_sys_i,
	input  wire logic       reset_n_i,
	// Operating mode and transceiver state
	input  wire logic       network_mode_i,
	input  wire logic       auto_mode_i,
	input  wire logic       state_deactivated_i,
	input  wire logic       state_test_i,
	input  wire logic       state_transparent_i,
	input  wire logic       activation_done_i,
	input  wire logic       tx_enable_i,
	// Command/indicate and monitor inputs
	input  wire logic [3:0] ci_code_i,
	input  wire logic       ci_valid_i,
	input  wire logic [7:0] local_command_monitor_i,
	input  wire logic       local_command_valid_i,
	input  wire logic [7:0] remote_channel_monitor_i,
	input  wire logic       remote_channel_valid_i,
	// Highway pins
	input  wire logic       frame_sync_clock_i,
	input  wire logic       highway_bit_clock_i,
	input  wire logic       highway_in_pin_i,
	input  wire logic       highway_out_data_i,
	output logic            highway_out_pin_o,
	output logic            highway_in_data_o,
	// Indications and status
	output logic [3:0]      ci_indicate_o,
	output logic            ci_indicate_valid_o,
	output logic [7:0]      remote_forward_o,
	output logic            remote_forward_valid_o,
	output logic            device_reset_o,
	output logic            line_tx_enable_o,
	output logic            analog_loop_o,
	output logic            complete_loop_o,
	output logic            first_loop_o,
	output logic            second_loop_o,
	output logic            loop_overrun_o
);

	// ----------------------------------------------------------------
	// Command decode
	// ----------------------------------------------------------------
	u_loop_pkg::analog_state_type astate_reg;   // Analog loop sequencer
	u_loop_pkg::analog_state_type astate_next;  // Its next value
	logic soft_reset;          // Reset code taken
	logic analog_req;          // Analog request accepted
	logic remote_complete;     // Remote 50 executed in auto mode
	logic local_complete_ok;   // Local F1 accepted
	logic open_all;            // Return to normal from local side, or remote in auto mode
	logic complete_pending_reg;// Remote 50 seen, waiting for local F1
	logic complete_reg;        // Complete loop latch
	logic first_reg;           // First channel loop latch
	logic second_reg;          // Second channel loop latch

	// The reset code is always taken from the highway, even while looped
	assign soft_reset = ci_valid_i && (ci_code_i == `CI_RESET_CODE);
	// Accept only from the state matching the line end
	assign analog_req = ci_valid_i && (ci_code_i == `CI_LOOP_ACT_REQ)
		&& (astate_reg == u_loop_pkg::ALOOP_OPEN)
		&& ((!network_mode_i && state_deactivated_i)
		|| (network_mode_i && state_test_i));
	assign remote_complete = remote_channel_valid_i && auto_mode_i
		&& (remote_channel_monitor_i == `MSG_REMOTE_COMPLETE);
	// Auto mode needs an earlier remote request; transparent needs none
	assign local_complete_ok = local_command_valid_i
		&& (local_command_monitor_i == `MSG_LOCAL_COMPLETE)
		&& (!auto_mode_i || complete_pending_reg);
	assign open_all = (local_command_valid_i
		&& local_command_monitor_i == `MSG_LOCAL_NORMAL)
		|| (remote_channel_valid_i && auto_mode_i
		&& remote_channel_monitor_i == `MSG_RETURN_NORMAL);

	// ----------------------------------------------------------------
	// Analog loop sequencer
	// ----------------------------------------------------------------
	// Next state: exchange end closes at once, network end waits for activation
	always_comb
	begin
		astate_next = astate_reg;
		unique case (astate_reg)
			u_loop_pkg::ALOOP_OPEN:
				if (analog_req)
					astate_next = network_mode_i ? u_loop_pkg::ALOOP_WAIT_ACT
						: u_loop_pkg::ALOOP_CLOSED;
			u_loop_pkg::ALOOP_WAIT_ACT:
				if (activation_done_i)
					astate_next = u_loop_pkg::ALOOP_CLOSED;
			u_loop_pkg::ALOOP_CLOSED:
				astate_next = u_loop_pkg::ALOOP_CLOSED;
			default:
				astate_next = u_loop_pkg::ALOOP_OPEN;
		endcase
	end

	// Only a device reset opens the analog loop, so coefficients re-converge
	always_ff @(posedge clk_sys_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			astate_reg <= u_loop_pkg::ALOOP_OPEN;
		else if (soft_reset)
			astate_reg <= u_loop_pkg::ALOOP_OPEN;
		else
			astate_reg <= astate_next;
	end

	assign analog_loop_o = (astate_reg != u_loop_pkg::ALOOP_OPEN);
	// Transmitter stays on so the far station activates too
	assign line_tx_enable_o = tx_enable_i | analog_loop_o;

	// ----------------------------------------------------------------
	// Digital loop latches
	// ----------------------------------------------------------------
	// Each latch is independent so both channel loops can stand together
	always_ff @(posedge clk_sys_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			complete_pending_reg <= 1'b0;
			complete_reg         <= 1'b0;
			first_reg            <= 1'b0;
			second_reg           <= 1'b0;
		end
		else if (soft_reset || open_all)
		begin
			// Opening leaves the line state untouched: no reset needed
			complete_pending_reg <= 1'b0;
			complete_reg         <= 1'b0;
			first_reg            <= 1'b0;
			second_reg           <= 1'b0;
		end
		else
		begin
			if (remote_complete)
				complete_pending_reg <= 1'b1;
			if (local_complete_ok)
				complete_reg <= 1'b1;
			if ((remote_channel_valid_i && auto_mode_i
				&& remote_channel_monitor_i == `MSG_REMOTE_FIRST)
				|| (local_command_valid_i
				&& local_command_monitor_i == `MSG_LOCAL_FIRST))
				first_reg <= 1'b1;
			if ((remote_channel_valid_i && auto_mode_i
				&& remote_channel_monitor_i == `MSG_REMOTE_SECOND)
				|| (local_command_valid_i
				&& local_command_monitor_i == `MSG_LOCAL_SECOND))
				second_reg <= 1'b1;
		end
	end

	assign complete_loop_o = complete_reg;
	assign first_loop_o    = first_reg;
	assign second_loop_o   = second_reg;

	// ----------------------------------------------------------------
	// Indications, forwarding and reset pulse
	// ----------------------------------------------------------------
	// One indication per cycle; analog steps win over the downstream request
	always_ff @(posedge clk_sys_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			ci_indicate_o       <= 4'h0;
			ci_indicate_valid_o <= 1'b0;
		end
		else if (analog_req && network_mode_i)
		begin
			ci_indicate_o       <= `CI_DEACT_CONFIRM;
			ci_indicate_valid_o <= 1'b1;
		end
		else if (astate_reg == u_loop_pkg::ALOOP_WAIT_ACT && activation_done_i
			&& !soft_reset)
		begin
			ci_indicate_o       <= `CI_ACT_REQUEST;
			ci_indicate_valid_o <= 1'b1;
		end
		else if (remote_complete && !soft_reset)
		begin
			// Ask the downstream device to loop rather than closing here
			ci_indicate_o       <= state_transparent_i ? `CI_ACT_IND_LOOP
				: `CI_LOOP_ACT_REQ;
			ci_indicate_valid_o <= 1'b1;
		end
		else
			ci_indicate_valid_o <= 1'b0;
	end

	// Transparent mode hands every remote message to the controller
	always_ff @(posedge clk_sys_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			remote_forward_o       <= 8'h00;
			remote_forward_valid_o <= 1'b0;
		end
		else
		begin
			remote_forward_valid_o <= remote_channel_valid_i && !auto_mode_i;
			if (remote_channel_valid_i && !auto_mode_i)
				remote_forward_o <= remote_channel_monitor_i;
		end
	end

	// Pulse tells the transceiver core to return to its test state
	always_ff @(posedge clk_sys_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			device_reset_o <= 1'b0;
		else
			device_reset_o <= soft_reset;
	end

	// ----------------------------------------------------------------
	// Highway pin synchronisers and frame position
	// ----------------------------------------------------------------
	logic [2:0] bclk_sync_reg;   // Bit clock: two sync stages plus history
	logic [2:0] fsc_sync_reg;    // Frame sync: two sync stages plus history
	logic [1:0] din_sync_reg;    // Input data pin
	logic       bit_edge;        // Rising edge of bit clock
	logic       frame_edge;      // Rising edge of frame sync
	logic [4:0] pos_reg;         // Bit position within frame
	logic       in_slot;         // Current bit belongs to a closed loop

	always_ff @(posedge clk_sys_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			bclk_sync_reg <= 3'h0;
			fsc_sync_reg  <= 3'h0;
			din_sync_reg  <= 2'h0;
		end
		else
		begin
			bclk_sync_reg <= {bclk_sync_reg[1:0], highway_bit_clock_i};
			fsc_sync_reg  <= {fsc_sync_reg[1:0], frame_sync_clock_i};
			din_sync_reg  <= {din_sync_reg[0], highway_in_pin_i};
		end
	end

	// Edge detectors read only the second and third stages
	assign bit_edge   = bclk_sync_reg[1] & ~bclk_sync_reg[2];
	assign frame_edge = fsc_sync_reg[1] & ~fsc_sync_reg[2];

	// Frame sync restarts the count; bit clock steps it
	always_ff @(posedge clk_sys_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			pos_reg <= `FRAME_POS_ZERO;
		else if (frame_edge)
			pos_reg <= `FRAME_POS_ZERO;
		else if (bit_edge)
			pos_reg <= pos_reg + `FRAME_POS_STEP;
	end

	// Complete loop covers both channels and the D bits
	assign in_slot = ((first_reg || complete_reg)
		&& pos_reg >= `SLOT_FIRST_LO && pos_reg <= `SLOT_FIRST_HI)
		|| ((second_reg || complete_reg)
		&& pos_reg >= `SLOT_SECOND_LO && pos_reg <= `SLOT_SECOND_HI)
		|| (complete_reg && pos_reg >= `SLOT_D_LO && pos_reg <= `SLOT_D_HI);

	// ----------------------------------------------------------------
	// Loop data path
	// ----------------------------------------------------------------
	logic       fifo_in_ready;   // FIFO can take a bit
	logic       fifo_out_valid;  // FIFO holds a bit
	logic [0:0] fifo_out_data;   // Oldest looped bit

	// Output bits are buffered so the return path sees them one bit later;
	// a stalled drain shows as overrun rather than silent loss
	loop_fifo #(
		.WIDTH (1),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk_sys_i   (clk_sys_i),
		.reset_n_i   (reset_n_i),
		.flush_i     (frame_edge),
		.in_data_i   (highway_out_data_i),
		.in_valid_i  (bit_edge),
		.in_ready_o  (fifo_in_ready),
		.out_data_o  (fifo_out_data),
		.out_valid_o (fifo_out_valid),
		.out_ready_i (bit_edge)
	);

	// Looped bits replace input data; output data still leaves normally
	always_ff @(posedge clk_sys_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			highway_out_pin_o <= 1'b0;
			highway_in_data_o <= 1'b1;
			loop_overrun_o    <= 1'b0;
		end
		else
		begin
			highway_out_pin_o <= highway_out_data_i;
			if (bit_edge)
				highway_in_data_o <= (in_slot && fifo_out_valid) ? fifo_out_data[0]
					: din_sync_reg[1];
			if (soft_reset)
				loop_overrun_o <= 1'b0;
			else if (bit_edge && !fifo_in_ready)
				loop_overrun_o <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!reset_n_i);

	sequence s_net_req;
		analog_req && network_mode_i;
	endsequence
	sequence s_dc_out;
		ci_indicate_valid_o && ci_indicate_o == `CI_DEACT_CONFIRM;
	endsequence

	AST_LINE_DRIVEN: assert property (analog_loop_o |-> line_tx_enable_o)
		else $error("Line not driven while analog loop closed");
	AST_ANALOG_CLOSE: assert property (analog_req && !soft_reset |=> analog_loop_o)
		else $error("Analog loop did not close on request");
	AST_RESET_OPENS: assert property (soft_reset |=> !analog_loop_o && !complete_reg
		&& !first_reg && !second_reg && device_reset_o)
		else $error("Reset code did not open loops");
	AST_STATE_GATE: assert property ($rose(analog_loop_o) |-> $past(network_mode_i)
		? $past(state_test_i) : $past(state_deactivated_i))
		else $error("Analog loop closed from wrong state");
	AST_NET_DC: assert property (s_net_req |=> s_dc_out)
		else $error("Deactivate-confirm not indicated");
	// A fresh F1 right after the opening command may close the loop again
	AST_OPEN_ALL: assert property (open_all && !soft_reset |=> !complete_reg
		&& !first_reg && !second_reg
		##1 (!complete_reg || $past(local_complete_ok)))
		else $error("Return to normal left a loop closed");
	AST_AUTO_GATE: assert property ($rose(complete_reg) && $past(auto_mode_i)
		|-> $past(complete_pending_reg))
		else $error("Complete loop closed without remote request");
	// The remote request alone must leave the complete latch where it was
	AST_DOWNSTREAM: assert property (remote_complete && !soft_reset && !analog_req
		&& !local_complete_ok && !open_all
		&& !(astate_reg == u_loop_pkg::ALOOP_WAIT_ACT && activation_done_i)
		|=> ci_indicate_valid_o && ci_indicate_o == ($past(state_transparent_i)
		? `CI_ACT_IND_LOOP : `CI_LOOP_ACT_REQ) && $stable(complete_reg))
		else $error("Downstream loop request wrong");
	AST_FORWARD: assert property (remote_channel_valid_i && !auto_mode_i
		|=> remote_forward_valid_o
		&& remote_forward_o == $past(remote_channel_monitor_i))
		else $error("Remote message not forwarded");
	AST_LATCH_HOLD: assert property (first_reg && !open_all && !soft_reset
		|=> first_reg)
		else $error("First channel loop dropped");

endmodule : u_line_loopback_control
`default_nettype wire

// ---- verif/highway_partner_model.sv ----
// Far-side highway model: frame sync, bit clock and the controller's data pin.
// Assumes the bench raises run_i once the highway should carry frames.
`timescale 1ns/1ps
`default_nettype none

module highway_partner_model (
	// Bench control
	input  wire logic run_i,
	// Highway lines toward the block
	output logic      frame_sync_clock_o,
	output logic      highway_bit_clock_o,
	output logic      highway_in_pin_o
);
	logic [4:0] bit_pos; // Bit position inside the frame

	// ----------------------------------------------------------------
	// Frame generator, 200 ns bits, offset from the system clock
	// ----------------------------------------------------------------
	initial
	begin
		frame_sync_clock_o  = 1'b0;
		highway_bit_clock_o = 1'b0;
		highway_in_pin_o    = 1'b0;
		bit_pos             = 5'h00;
		#7;
		forever
		begin
			// Released pin keeps changing so a stale value never looks valid
			if (!run_i)
			begin
				#100 highway_in_pin_o = ~highway_in_pin_o;
			end
			else
			begin
				// Clocks run in whole frames of 32 bits
				repeat (32)
				begin
					frame_sync_clock_o = (bit_pos == 5'h00);
					highway_in_pin_o   = bit_pos[0] ^ bit_pos[2];
					#100 highway_bit_clock_o = 1'b1;
					#100 highway_bit_clock_o = 1'b0;
					bit_pos = bit_pos + 5'h01;
				end
				frame_sync_clock_o = 1'b0;
			end
		end
	end
endmodule : highway_partner_model

`default_nettype wire

// ---- verif/u_line_loopback_control_tb.sv ----
// Self-checking bench for the loop-back control.
// Assumes the design files and the partner model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "u_loop_regs.svh"

module u_line_loopback_control_tb;
	logic       clk, rst_n, net, auto, deact, tst, transp, act_done, tx_en;
	logic [3:0] ci_code;
	logic [7:0] loc_cmd, rem_msg;
	logic       ci_valid, loc_valid, rem_valid, out_data, run_hw;
	wire logic  frame_sync_clock, highway_bit_clock, hw_pin;
	logic       out_pin, in_data, ind_valid, fwd_valid, dev_rst, line_tx;
	logic       analog, complete, first, second, overrun;
	logic [3:0] ind_code;
	logic [7:0] fwd_msg;
	int         bad_count;       // Mismatches seen
	int         samples_checked; // Comparisons made

	highway_partner_model partner (.run_i(run_hw), .frame_sync_clock_o(frame_sync_clock),
		.highway_bit_clock_o(highway_bit_clock), .highway_in_pin_o(hw_pin));

	u_line_loopback_control #(.FIFO_DEPTH(8)) uut (.clk_sys_i(clk), .reset_n_i(rst_n),
		.network_mode_i(net), .auto_mode_i(auto), .state_deactivated_i(deact),
		.state_test_i(tst), .state_transparent_i(transp), .activation_done_i(act_done),
		.tx_enable_i(tx_en), .ci_code_i(ci_code), .ci_valid_i(ci_valid),
		.local_command_monitor_i(loc_cmd), .local_command_valid_i(loc_valid),
		.remote_channel_monitor_i(rem_msg), .remote_channel_valid_i(rem_valid),
		.frame_sync_clock_i(frame_sync_clock), .highway_bit_clock_i(highway_bit_clock), .highway_in_pin_i(hw_pin),
		.highway_out_data_i(out_data), .highway_out_pin_o(out_pin),
		.highway_in_data_o(in_data), .ci_indicate_o(ind_code),
		.ci_indicate_valid_o(ind_valid), .remote_forward_o(fwd_msg),
		.remote_forward_valid_o(fwd_valid), .device_reset_o(dev_rst),
		.line_tx_enable_o(line_tx), .analog_loop_o(analog), .complete_loop_o(complete),
		.first_loop_o(first), .second_loop_o(second), .loop_overrun_o(overrun));

	// ----------------------------------------------------------------
	// Clock, 25 ns period
	// ----------------------------------------------------------------
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : print_verdict

	task automatic check_bit(input string name, input logic exp, input logic got);
		samples_checked++;
		if (got !== exp)
		begin
			bad_count++;
			$display("mismatch %s expected %b seen %b", name, exp, got);
		end
	endtask : check_bit

	task automatic check_code(input string name, input logic [7:0] exp, input logic [7:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask : check_code

	task automatic check_loops(input logic c, input logic f, input logic s);
		check_bit("complete_loop", c, complete);
		check_bit("first_loop", f, first);
		check_bit("second_loop", s, second);
	endtask : check_loops

	// One-cycle request: 0 code, 1 local monitor, 2 remote; returns after the taking edge
	task automatic send(input int kind, input logic [7:0] v);
		@(negedge clk);
		if (kind == 0)
		begin
			ci_code  = v[3:0];
			ci_valid = 1'b1;
		end
		else if (kind == 1)
		begin
			loc_cmd   = v;
			loc_valid = 1'b1;
		end
		else
		begin
			rem_msg   = v;
			rem_valid = 1'b1;
		end
		@(negedge clk);
		ci_valid  = 1'b0;
		loc_valid = 1'b0;
		rem_valid = 1'b0;
	endtask : send

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic test_exchange_analog;
		{net, deact, tst, tx_en} = 4'h4;
		send(0, `CI_RESET_CODE);
		check_bit("device_reset", 1'b1, dev_rst);
		send(0, `CI_LOOP_ACT_REQ);
		@(negedge clk);
		check_bit("analog_loop", 1'b1, analog);
		check_bit("line_tx_enable", 1'b1, line_tx);
		send(0, `CI_RESET_CODE);
		@(negedge clk);
		check_bit("analog_loop", 1'b0, analog);
		{deact, tst} = 2'b01;
		send(0, `CI_LOOP_ACT_REQ);
		@(negedge clk);
		check_bit("analog_loop", 1'b0, analog);
		$display("test exchange_analog done");
	endtask : test_exchange_analog

	task automatic test_network_analog;
		{net, tst, run_hw} = 3'b111;
		repeat (20) @(negedge clk);
		send(0, `CI_LOOP_ACT_REQ);
		check_bit("indicate_valid", 1'b1, ind_valid);
		check_code("indicate", {4'h0, `CI_DEACT_CONFIRM}, {4'h0, ind_code});
		@(negedge clk);
		check_bit("analog_loop", 1'b1, analog);
		act_done = 1'b1;
		@(negedge clk);
		act_done = 1'b0;
		check_code("indicate", {4'h0, `CI_ACT_REQUEST}, {4'h0, ind_code});
		rst_n = 1'b0;
		@(negedge clk);
		rst_n = 1'b1;
		check_bit("analog_loop", 1'b0, analog);
		$display("test network_analog done");
	endtask : test_network_analog

	task automatic test_auto_complete;
		{auto, tst, transp} = 3'b101;
		send(1, `MSG_LOCAL_COMPLETE);
		@(negedge clk);
		check_bit("complete_loop", 1'b0, complete);
		send(2, `MSG_REMOTE_COMPLETE);
		check_code("indicate", {4'h0, `CI_ACT_IND_LOOP}, {4'h0, ind_code});
		send(1, `MSG_LOCAL_COMPLETE);
		@(negedge clk);
		check_loops(1'b1, 1'b0, 1'b0);
		send(2, `MSG_RETURN_NORMAL);
		@(negedge clk);
		check_loops(1'b0, 1'b0, 1'b0);
		transp = 1'b0;
		send(2, `MSG_REMOTE_COMPLETE);
		check_code("indicate", {4'h0, `CI_LOOP_ACT_REQ}, {4'h0, ind_code});
		send(1, `MSG_LOCAL_COMPLETE);
		send(0, `CI_RESET_CODE);
		check_bit("device_reset", 1'b1, dev_rst);
		@(negedge clk);
		check_loops(1'b0, 1'b0, 1'b0);
		$display("test auto_complete done");
	endtask : test_auto_complete

	task automatic test_auto_channels;
		send(2, `MSG_REMOTE_FIRST);
		send(2, `MSG_REMOTE_SECOND);
		@(negedge clk);
		check_loops(1'b0, 1'b1, 1'b1);
		// Own output high; pin is low at bits 2, 10 and 18 of each frame
		out_data = 1'b1;
		@(posedge frame_sync_clock);
		// Sample mid-bit: bit k stands from about 155 ns to 355 ns after 200*k
		#650;
		check_bit("highway_in_data", 1'b1, in_data);
		#1600;
		check_bit("highway_in_data", 1'b1, in_data);
		#1600;
		check_bit("highway_in_data", 1'b0, in_data);
		check_bit("loop_overrun", 1'b0, overrun);
		send(1, `MSG_LOCAL_NORMAL);
		check_bit("device_reset", 1'b0, dev_rst);
		@(negedge clk);
		check_loops(1'b0, 1'b0, 1'b0);
		$display("test auto_channels done");
	endtask : test_auto_channels

	task automatic test_transparent;
		auto = 1'b0;
		send(2, `MSG_REMOTE_COMPLETE);
		check_bit("forward_valid", 1'b1, fwd_valid);
		check_code("forward", `MSG_REMOTE_COMPLETE, fwd_msg);
		send(1, `MSG_LOCAL_COMPLETE);
		send(1, `MSG_LOCAL_FIRST);
		send(1, `MSG_LOCAL_SECOND);
		@(negedge clk);
		check_loops(1'b1, 1'b1, 1'b1);
		send(2, `MSG_RETURN_NORMAL);
		@(negedge clk);
		check_loops(1'b1, 1'b1, 1'b1);
		send(1, `MSG_LOCAL_NORMAL);
		@(negedge clk);
		check_loops(1'b0, 1'b0, 1'b0);
		$display("test transparent done");
	endtask : test_transparent

	task automatic test_onward;
		for (int i = 0; i < 4; i++)
		begin
			out_data = i[0] ^ i[1];
			@(negedge clk);
			check_bit("highway_out_pin", i[0] ^ i[1], out_pin);
		end
		$display("test onward done");
	endtask : test_onward

	// ----------------------------------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------------------------------
	initial
	begin
		{rst_n, net, auto, deact, tst, transp, act_done, tx_en} = 8'h00;
		{ci_code, loc_cmd, rem_msg} = 20'h00000;
		{ci_valid, loc_valid, rem_valid, out_data, run_hw} = 5'h00;
		bad_count = 0;
		samples_checked = 0;
		repeat (4) @(negedge clk);
		check_loops(1'b0, 1'b0, 1'b0);
		check_bit("highway_in_data", 1'b1, in_data);
		rst_n = 1'b1;
		test_exchange_analog();
		test_network_analog();
		test_auto_complete();
		test_auto_channels();
		test_transparent();
		test_onward();
		print_verdict();
	end

	initial
	begin
		#2000000;
		bad_count++;
		print_verdict();
	end
endmodule : u_line_loopback_control_tb

`default_nettype wire
